// ### ppb_regs.svh
// Register offsets, reset values and widths of the parallel port bank
`ifndef PPB_REGS_SVH
`define PPB_REGS_SVH

`define PPB_OFS_P1_OUT_LATCH 6'h01
`define PPB_OFS_P2_OUT_LATCH 6'h02
`define PPB_OFS_P3_OUT_LATCH 6'h03
`define PPB_OFS_P3_DRIVE_TYPE 6'h04
`define PPB_OFS_P1_PIN_LEVEL 6'h08
`define PPB_OFS_P2_PIN_LEVEL 6'h09
`define PPB_OFS_P3_PIN_LEVEL 6'h0a
`define PPB_OFS_P1_SEG_SELECT 6'h29

`define PPB_RST_P1_OUT_LATCH 8'hff
`define PPB_RST_P1_SEG_SELECT 8'h00
`define PPB_RST_P2_OUT_LATCH 3'h7
`define PPB_RST_P3_OUT_LATCH 4'hf
`define PPB_RST_P3_DRIVE_TYPE 4'h0
`define PPB_RST_PIN_LEVEL_P1 8'hff
`define PPB_RST_PIN_LEVEL_P2 3'h7
`define PPB_RST_PIN_LEVEL_P3 4'hf

`define PPB_UNMAPPED_DATA 8'h00
`define PPB_P2_HIGH_FILL 5'h00
`define PPB_P3_HIGH_FILL 4'h0

`endif

// ### ppb_pkg.sv
// Types shared by the parallel port bank
package ppb_pkg;
    typedef logic [5:0] ppb_addr_t;
    typedef logic [7:0] ppb_byte_t;
    typedef logic [2:0] ppb_p2_t;
    typedef logic [3:0] ppb_p3_t;
endpackage

// ### ppb_sync.sv
// Three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/10ps
module ppb_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Asynchronous pin levels in, accepted levels out
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_nxt;

    // Stage one feeds stage two only; the agreement check filters a late flip
    always_comb begin
        level_nxt = level_o;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                level_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            level_o <= INIT;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_o <= level_nxt;
        end
    end
endmodule

// ### ppb_top.sv
// Parallel port bank: 8-bit port 1, 3-bit port 2 and 4-bit port 3 with their registers
`timescale 1ns/10ps
`include "ppb_regs.svh"
module ppb_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // CPU register bus
    input wire ppb_pkg::ppb_addr_t bus_addr_i,
    input wire ppb_pkg::ppb_byte_t bus_wdata_i,
    input wire logic bus_wr_s2_i,
    input wire logic bus_rd_s1_i,
    output ppb_pkg::ppb_byte_t bus_rdata_o,
    // Port 1 pins and shared functions
    input wire ppb_pkg::ppb_byte_t p1_pin_i,
    output ppb_pkg::ppb_byte_t p1_pin_o,
    output ppb_pkg::ppb_byte_t p1_pin_oe_o,
    input wire ppb_pkg::ppb_byte_t p1_seg_data_i,
    input wire ppb_pkg::ppb_byte_t p1_alt_out_i,
    output ppb_pkg::ppb_byte_t p1_level_o,
    // Port 2 pins, oscillator and stop control
    input wire ppb_pkg::ppb_p2_t p2_pin_i,
    output ppb_pkg::ppb_p2_t p2_pin_o,
    output ppb_pkg::ppb_p2_t p2_pin_oe_o,
    input wire ppb_pkg::ppb_p2_t p2_alt_out_i,
    input wire logic dual_clock_mode_i,
    input wire logic stop_mode_i,
    input wire logic stop_output_enable_i,
    output ppb_pkg::ppb_p2_t p2_level_o,
    output logic ext_int_fall_o,
    // Port 3 pins and shared functions
    input wire ppb_pkg::ppb_p3_t p3_pin_i,
    output ppb_pkg::ppb_p3_t p3_pin_o,
    output ppb_pkg::ppb_p3_t p3_pin_oe_o,
    input wire ppb_pkg::ppb_p3_t p3_alt_out_i,
    output ppb_pkg::ppb_p3_t p3_level_o
);
    import ppb_pkg::*;

    ppb_byte_t port1_out_latch_r, port1_out_latch_nxt;
    ppb_byte_t port1_segment_select_r, port1_segment_select_nxt;
    ppb_p2_t port2_out_latch_r, port2_out_latch_nxt;
    ppb_p3_t port3_out_latch_r, port3_out_latch_nxt;
    ppb_p3_t port3_drive_type_r, port3_drive_type_nxt;
    ppb_byte_t rdata_nxt;
    ppb_byte_t p1_pin_nxt, p1_oe_nxt;
    ppb_p2_t p2_pin_nxt, p2_oe_nxt;
    ppb_p3_t p3_pin_nxt, p3_oe_nxt;
    logic p2_bit0_prev_r;
    logic ext_int_fall_nxt;
    logic stop_float;

    ppb_byte_t p1_sync;
    ppb_p2_t p2_sync;
    ppb_p3_t p3_sync;

    // Pins are live and unlatched; only the synchroniser stands before them
    ppb_sync #(.W(8), .INIT(`PPB_RST_PIN_LEVEL_P1)) u_p1_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pin_i(p1_pin_i),
        .level_o(p1_sync)
    );
    ppb_sync #(.W(3), .INIT(`PPB_RST_PIN_LEVEL_P2)) u_p2_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pin_i(p2_pin_i),
        .level_o(p2_sync)
    );
    ppb_sync #(.W(4), .INIT(`PPB_RST_PIN_LEVEL_P3)) u_p3_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pin_i(p3_pin_i),
        .level_o(p3_sync)
    );

    // Register writes, applied on the S2 strobe
    always_comb begin
        port1_out_latch_nxt = port1_out_latch_r;
        port1_segment_select_nxt = port1_segment_select_r;
        port2_out_latch_nxt = port2_out_latch_r;
        port3_out_latch_nxt = port3_out_latch_r;
        port3_drive_type_nxt = port3_drive_type_r;
        if (bus_wr_s2_i) begin
            case (bus_addr_i)
                `PPB_OFS_P1_OUT_LATCH: port1_out_latch_nxt = bus_wdata_i;
                `PPB_OFS_P1_SEG_SELECT: port1_segment_select_nxt = bus_wdata_i;
                `PPB_OFS_P2_OUT_LATCH: port2_out_latch_nxt = bus_wdata_i[2:0];
                `PPB_OFS_P3_OUT_LATCH: port3_out_latch_nxt = bus_wdata_i[3:0];
                `PPB_OFS_P3_DRIVE_TYPE: port3_drive_type_nxt = bus_wdata_i[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            port1_out_latch_r <= `PPB_RST_P1_OUT_LATCH;
            port1_segment_select_r <= `PPB_RST_P1_SEG_SELECT;
            port2_out_latch_r <= `PPB_RST_P2_OUT_LATCH;
            port3_out_latch_r <= `PPB_RST_P3_OUT_LATCH;
            port3_drive_type_r <= `PPB_RST_P3_DRIVE_TYPE;
        end else begin
            port1_out_latch_r <= port1_out_latch_nxt;
            port1_segment_select_r <= port1_segment_select_nxt;
            port2_out_latch_r <= port2_out_latch_nxt;
            port3_out_latch_r <= port3_out_latch_nxt;
            port3_drive_type_r <= port3_drive_type_nxt;
        end
    end

    // Register reads; pin levels are captured on the S1 strobe and held
    always_comb begin
        rdata_nxt = bus_rdata_o;
        if (bus_rd_s1_i) begin
            case (bus_addr_i)
                `PPB_OFS_P1_OUT_LATCH: rdata_nxt = port1_out_latch_r;
                `PPB_OFS_P1_SEG_SELECT: rdata_nxt = port1_segment_select_r;
                `PPB_OFS_P2_OUT_LATCH: rdata_nxt = {`PPB_P2_HIGH_FILL, port2_out_latch_r};
                `PPB_OFS_P3_OUT_LATCH: rdata_nxt = {`PPB_P3_HIGH_FILL, port3_out_latch_r};
                `PPB_OFS_P3_DRIVE_TYPE: rdata_nxt = {`PPB_P3_HIGH_FILL, port3_drive_type_r};
                // Segment bits read whatever the segment driver puts on the pin
                `PPB_OFS_P1_PIN_LEVEL: rdata_nxt = p1_sync;
                `PPB_OFS_P2_PIN_LEVEL: rdata_nxt = {`PPB_P2_HIGH_FILL, p2_sync};
                `PPB_OFS_P3_PIN_LEVEL: rdata_nxt = {`PPB_P3_HIGH_FILL, p3_sync};
                default: rdata_nxt = `PPB_UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            bus_rdata_o <= `PPB_UNMAPPED_DATA;
        end else begin
            bus_rdata_o <= rdata_nxt;
        end
    end

    // Pin drive; port functions sink only, except segment bits and push-pull port 3 bits, so a latch of 1 lets the pin be read
    always_comb begin
        stop_float = stop_mode_i && !stop_output_enable_i;
        for (int i = 0; i < 8; i++) begin
            if (port1_segment_select_r[i]) begin
                p1_pin_nxt[i] = p1_seg_data_i[i];
                p1_oe_nxt[i] = 1'b1;
            end else begin
                p1_pin_nxt[i] = port1_out_latch_r[i] & p1_alt_out_i[i];
                p1_oe_nxt[i] = !p1_pin_nxt[i];
            end
            if (stop_float) begin
                p1_oe_nxt[i] = 1'b0;
            end
        end
        for (int i = 0; i < 3; i++) begin
            p2_pin_nxt[i] = port2_out_latch_r[i] & p2_alt_out_i[i];
            p2_oe_nxt[i] = !p2_pin_nxt[i] && !stop_float;
        end
        if (dual_clock_mode_i) begin
            p2_oe_nxt[2:1] = 2'b00;
        end
        if (stop_mode_i) begin
            p2_oe_nxt[0] = 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            p3_pin_nxt[i] = port3_out_latch_r[i] & p3_alt_out_i[i];
            p3_oe_nxt[i] = (port3_drive_type_r[i] || !p3_pin_nxt[i]) && !stop_float;
        end
    end

    // Falling edge taken from the pin itself, so a driven low also counts
    always_comb begin
        ext_int_fall_nxt = p2_bit0_prev_r && !p2_sync[0];
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            p1_pin_o <= `PPB_RST_P1_OUT_LATCH;
            p1_pin_oe_o <= 8'h00;
            p2_pin_o <= `PPB_RST_P2_OUT_LATCH;
            p2_pin_oe_o <= 3'h0;
            p3_pin_o <= `PPB_RST_P3_OUT_LATCH;
            p3_pin_oe_o <= 4'h0;
            p1_level_o <= `PPB_RST_PIN_LEVEL_P1;
            p2_level_o <= `PPB_RST_PIN_LEVEL_P2;
            p3_level_o <= `PPB_RST_PIN_LEVEL_P3;
            p2_bit0_prev_r <= 1'b1;
            ext_int_fall_o <= 1'b0;
        end else begin
            p1_pin_o <= p1_pin_nxt;
            p1_pin_oe_o <= p1_oe_nxt;
            p2_pin_o <= p2_pin_nxt;
            p2_pin_oe_o <= p2_oe_nxt;
            p3_pin_o <= p3_pin_nxt;
            p3_pin_oe_o <= p3_oe_nxt;
            p1_level_o <= p1_sync;
            p2_level_o <= p2_sync;
            p3_level_o <= p3_sync;
            p2_bit0_prev_r <= p2_sync[0];
            ext_int_fall_o <= ext_int_fall_nxt;
        end
    end

    // Checks
    p1_reset_ones_a: assert property (@(posedge sys_clk_i)
        $rose(rstn_i) |-> port1_out_latch_r == 8'hff && port2_out_latch_r == 3'h7)
        else $error("Port latches not all ones after reset");
    p3_reset_od_a: assert property (@(posedge sys_clk_i)
        $rose(rstn_i) |-> port3_out_latch_r == 4'hf && port3_drive_type_r == 4'h0 && p3_pin_oe_o == 4'h0)
        else $error("Port 3 not open drain high after reset");
    p1_write_s2_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        bus_wr_s2_i && bus_addr_i == 6'h01 && !stop_float && port1_segment_select_r == 8'h00
        && p1_alt_out_i == 8'hff ##1 p1_alt_out_i == 8'hff && !stop_float && port1_segment_select_r == 8'h00
        |=> p1_pin_o == $past(bus_wdata_i, 2))
        else $error("Port 1 pin did not follow the written latch");
    p1_segment_route_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        port1_segment_select_r[0] && !stop_float |=> p1_pin_o[0] == $past(p1_seg_data_i[0]) && p1_pin_oe_o[0])
        else $error("Segment data not routed to port 1 pin");
    p2_stop_float_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        stop_mode_i && stop_output_enable_i |=> !p2_pin_oe_o[0])
        else $error("Port 2 bit 0 driven in stop mode");
    p2_osc_pins_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        dual_clock_mode_i |=> p2_pin_oe_o[2:1] == 2'b00)
        else $error("Oscillator pins driven in dual clock mode");
    p2_fall_int_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        p2_sync[0] ##1 !p2_sync[0] |=> ext_int_fall_o ##1 !ext_int_fall_o)
        else $error("Port 2 bit 0 fall not flagged once");
    p3_drive_type_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !stop_float && port3_drive_type_r[0] == 1'b0 && p3_pin_nxt[0] |=> !p3_pin_oe_o[0])
        else $error("Open drain bit drove a high level");
    p3_push_pull_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !stop_float && port3_drive_type_r[1] |=> p3_pin_oe_o[1])
        else $error("Push-pull bit not driven");
    p2_read_high_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        bus_rd_s1_i && bus_addr_i == 6'h09 |=> bus_rdata_o[7:3] == 5'h00 && bus_rdata_o[2:0] == $past(p2_sync))
        else $error("Port 2 pin read wrong");
    p3_read_pins_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        bus_rd_s1_i && bus_addr_i == 6'h0a |=> bus_rdata_o == {4'h0, $past(p3_sync)})
        else $error("Port 3 pin read not sampled at S1");
    latch_readback_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        bus_wr_s2_i && bus_addr_i == 6'h03 ##1 bus_rd_s1_i && bus_addr_i == 6'h03 && !bus_wr_s2_i
        |=> bus_rdata_o[3:0] == $past(bus_wdata_i[3:0], 2))
        else $error("Port 3 latch readback wrong");
endmodule

// ### ppb_pin_model.sv
// Pin-side partner: board pull-ups plus an optional external driver on each line
`timescale 1ns/10ps
module ppb_pin_model #(
    parameter int W = 8
) (
    // Device side of each line
    input wire logic [W-1:0] dev_val_i,
    input wire logic [W-1:0] dev_oe_i,
    // External driver set by the bench
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_val_i,
    // Resolved wire level
    output logic [W-1:0] wire_o
);
    // Released lines sit high on the board pull-up, which open-drain outputs need
    // A clash is not modelled: the bench never drives a line the device drives
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (dev_oe_i[i]) begin
                wire_o[i] = dev_val_i[i];
            end else if (ext_en_i[i]) begin
                wire_o[i] = ext_val_i[i];
            end else begin
                wire_o[i] = 1'b1;
            end
        end
    end
endmodule

// ### test_parallel_port_bank_p1_p3.sv
// Self-checking bench for the parallel port bank
`timescale 1ns/10ps
`include "ppb_regs.svh"
module test_parallel_port_bank_p1_p3;
    import ppb_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    ppb_addr_t addr = 6'h00;
    ppb_byte_t wdata = 8'h00;
    logic wr_s2 = 1'b0;
    logic rd_s1 = 1'b0;
    ppb_byte_t rdata;
    ppb_byte_t p1_in, p1_pin_o, p1_pin_oe_o, p1_lvl;
    ppb_byte_t p1_seg = 8'h00;
    ppb_byte_t p1_alt = 8'hff;
    ppb_byte_t p1_ext_en = 8'h00;
    ppb_byte_t p1_ext_val = 8'h00;
    ppb_p2_t p2_in, p2_pin_o, p2_pin_oe_o, p2_lvl;
    ppb_p2_t p2_alt = 3'h7;
    ppb_p2_t p2_ext_en = 3'h0;
    ppb_p2_t p2_ext_val = 3'h0;
    logic dual_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic stop_oe = 1'b0;
    logic ext_int_fall_o;
    ppb_p3_t p3_in, p3_pin_o, p3_pin_oe_o, p3_lvl;
    ppb_p3_t p3_alt = 4'hf;
    ppb_p3_t p3_ext_en = 4'h0;
    ppb_p3_t p3_ext_val = 4'h0;
    int miscompares = 0;
    int check_count = 0;

    ppb_top u_ppb_top (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus_addr_i(addr), .bus_wdata_i(wdata),
        .bus_wr_s2_i(wr_s2), .bus_rd_s1_i(rd_s1), .bus_rdata_o(rdata), .p1_pin_i(p1_in), .p1_pin_o(p1_pin_o),
        .p1_pin_oe_o(p1_pin_oe_o), .p1_seg_data_i(p1_seg), .p1_alt_out_i(p1_alt), .p1_level_o(p1_lvl),
        .p2_pin_i(p2_in), .p2_pin_o(p2_pin_o), .p2_pin_oe_o(p2_pin_oe_o), .p2_alt_out_i(p2_alt),
        .dual_clock_mode_i(dual_mode), .stop_mode_i(stop_mode), .stop_output_enable_i(stop_oe),
        .p2_level_o(p2_lvl), .ext_int_fall_o(ext_int_fall_o), .p3_pin_i(p3_in), .p3_pin_o(p3_pin_o),
        .p3_pin_oe_o(p3_pin_oe_o), .p3_alt_out_i(p3_alt), .p3_level_o(p3_lvl));
    ppb_pin_model #(.W(8)) u_ppb_pin_model_p1 (.dev_val_i(p1_pin_o), .dev_oe_i(p1_pin_oe_o),
        .ext_en_i(p1_ext_en), .ext_val_i(p1_ext_val), .wire_o(p1_in));
    ppb_pin_model #(.W(3)) u_ppb_pin_model_p2 (.dev_val_i(p2_pin_o), .dev_oe_i(p2_pin_oe_o),
        .ext_en_i(p2_ext_en), .ext_val_i(p2_ext_val), .wire_o(p2_in));
    ppb_pin_model #(.W(4)) u_ppb_pin_model_p3 (.dev_val_i(p3_pin_o), .dev_oe_i(p3_pin_oe_o),
        .ext_en_i(p3_ext_en), .ext_val_i(p3_ext_val), .wire_o(p3_in));

    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic finish_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Returns once the pin outputs have taken the new latch value
    task automatic wr(input ppb_addr_t a, input ppb_byte_t d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr_s2 <= 1'b1;
        @(posedge sys_clk_i);
        wr_s2 <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask

    task automatic rd(input ppb_addr_t a, input ppb_byte_t exp);
        @(posedge sys_clk_i);
        addr <= a;
        rd_s1 <= 1'b1;
        @(posedge sys_clk_i);
        rd_s1 <= 1'b0;
        @(posedge sys_clk_i);
        chk(rdata, exp);
    endtask

    // Write strobe followed at once by a read strobe of the same register
    task automatic wr_rd(input ppb_addr_t a, input ppb_byte_t d, input ppb_byte_t exp);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr_s2 <= 1'b1;
        @(posedge sys_clk_i);
        wr_s2 <= 1'b0;
        rd_s1 <= 1'b1;
        @(posedge sys_clk_i);
        rd_s1 <= 1'b0;
        @(posedge sys_clk_i);
        chk(rdata, exp);
    endtask

    // Pin levels pass a synchroniser before they can be read
    task automatic settle();
        repeat (8) @(posedge sys_clk_i);
    endtask

    task automatic wait_fall();
        int n;
        n = 0;
        while (ext_int_fall_o !== 1'b1 && n < 20) begin
            @(posedge sys_clk_i);
            n++;
        end
        chk({7'h00, ext_int_fall_o}, 8'h01);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        miscompares++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        finish_test();
    end

    initial begin
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        settle();
        rd(`PPB_OFS_P1_OUT_LATCH, 8'hff);
        rd(`PPB_OFS_P2_OUT_LATCH, 8'h07);
        rd(`PPB_OFS_P3_OUT_LATCH, 8'h0f);
        rd(`PPB_OFS_P3_DRIVE_TYPE, 8'h00);
        rd(`PPB_OFS_P1_SEG_SELECT, 8'h00);
        rd(`PPB_OFS_P1_PIN_LEVEL, 8'hff);
        rd(`PPB_OFS_P3_PIN_LEVEL, 8'h0f);
        wr(`PPB_OFS_P1_OUT_LATCH, 8'h55);
        chk(p1_pin_oe_o, 8'haa);
        chk(p1_pin_o & p1_pin_oe_o, 8'h00);
        settle();
        rd(`PPB_OFS_P1_OUT_LATCH, 8'h55);
        rd(`PPB_OFS_P1_PIN_LEVEL, 8'h55);
        wr(`PPB_OFS_P1_PIN_LEVEL, 8'h00);
        rd(`PPB_OFS_P1_PIN_LEVEL, 8'h55);
        wr(`PPB_OFS_P1_OUT_LATCH, 8'hff);
        p1_ext_en <= 8'hff;
        p1_ext_val <= 8'h3c;
        settle();
        rd(`PPB_OFS_P1_PIN_LEVEL, 8'h3c);
        chk(p1_lvl, 8'h3c);
        p1_ext_val <= 8'hc3;
        settle();
        rd(`PPB_OFS_P1_PIN_LEVEL, 8'hc3);
        p1_ext_en <= 8'h00;
        p1_alt <= 8'h0f;
        settle();
        chk(p1_pin_oe_o, 8'hf0);
        p1_alt <= 8'hff;
        p1_seg <= 8'h05;
        wr(`PPB_OFS_P1_SEG_SELECT, 8'h0f);
        chk({4'h0, p1_pin_oe_o[3:0]}, 8'h0f);
        chk({4'h0, p1_pin_o[3:0]}, 8'h05);
        wr(`PPB_OFS_P1_SEG_SELECT, 8'h00);
        wr(`PPB_OFS_P2_OUT_LATCH, 8'hfe);
        rd(`PPB_OFS_P2_OUT_LATCH, 8'h06);
        wait_fall();
        chk({5'h00, p2_pin_oe_o}, 8'h01);
        chk({5'h00, p2_pin_o}, 8'h06);
        chk({5'h00, p2_lvl}, 8'h06);
        dual_mode <= 1'b1;
        wr(`PPB_OFS_P2_OUT_LATCH, 8'h00);
        chk({5'h00, p2_pin_oe_o}, 8'h01);
        stop_mode <= 1'b1;
        stop_oe <= 1'b1;
        settle();
        chk({5'h00, p2_pin_oe_o}, 8'h00);
        stop_mode <= 1'b0;
        dual_mode <= 1'b0;
        wr(`PPB_OFS_P2_OUT_LATCH, 8'h07);
        wr(`PPB_OFS_P3_OUT_LATCH, 8'h0a);
        chk({4'h0, p3_pin_oe_o}, 8'h05);
        wr(`PPB_OFS_P3_DRIVE_TYPE, 8'h0f);
        chk({4'h0, p3_pin_oe_o}, 8'h0f);
        chk({4'h0, p3_pin_o}, 8'h0a);
        // Stop without the output enable releases every driven pin
        stop_mode <= 1'b1;
        stop_oe <= 1'b0;
        settle();
        chk({4'h0, p3_pin_oe_o}, 8'h00);
        stop_mode <= 1'b0;
        settle();
        rd(`PPB_OFS_P3_PIN_LEVEL, 8'h0a);
        p3_alt <= 4'h3;
        wr_rd(`PPB_OFS_P3_OUT_LATCH, 8'hff, 8'h0f);
        chk({4'h0, p3_pin_o}, 8'h03);
        p3_alt <= 4'hf;
        wr(`PPB_OFS_P3_DRIVE_TYPE, 8'h00);
        chk({4'h0, p3_pin_oe_o}, 8'h00);
        rd(`PPB_OFS_P3_DRIVE_TYPE, 8'h00);
        // Outside drivers on released lines: a pulled-low input must raise the fall pulse
        p2_ext_en <= 3'h1;
        p2_ext_val <= 3'h0;
        p3_ext_en <= 4'hf;
        p3_ext_val <= 4'h5;
        wait_fall();
        rd(`PPB_OFS_P2_PIN_LEVEL, 8'h06);
        rd(`PPB_OFS_P3_PIN_LEVEL, 8'h05);
        chk({4'h0, p3_lvl}, 8'h05);
        // Reset in mid-run must undo written latches and segment routing
        wr(`PPB_OFS_P1_OUT_LATCH, 8'h00);
        wr(`PPB_OFS_P1_SEG_SELECT, 8'ha5);
        chk(p1_pin_oe_o, 8'hff);
        rstn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        rd(`PPB_OFS_P1_OUT_LATCH, 8'hff);
        rd(`PPB_OFS_P1_SEG_SELECT, 8'h00);
        chk(p1_pin_oe_o, 8'h00);
        finish_test();
    end
endmodule
